//--- core/tcs_pkg.sv
package tcs_pkg;

   // register byte addresses on the apb word grid
   localparam logic [15:0] ADDR_TIMER_CONTROL   = 16'hFFC8;
   localparam logic [15:0] ADDR_COUNT_VALUE     = 16'hFFCC;
   localparam logic [15:0] ADDR_SERIAL_TIMER    = 16'hFFD0;
   localparam logic [15:0] ADDR_COMPARE_A       = 16'hFFD4;
   localparam logic [15:0] ADDR_COMPARE_B       = 16'hFFD8;
   localparam logic [15:0] ADDR_IRQ_STATUS      = 16'hFFDC;
   localparam logic [15:0] ADDR_IRQ_CLEAR       = 16'hFFE0;
   localparam logic [15:0] ADDR_IRQ_ENABLE      = 16'hFFE4;

   localparam int          ADDR_WIDTH           = 16;
   localparam int          DATA_WIDTH           = 32;

   // values after reset and standby, and the top count value
   localparam logic [7:0]  TIMER_CONTROL_RST    = 8'h00;
   localparam logic [7:0]  SERIAL_TIMER_RST     = 8'h00;
   localparam logic [7:0]  COUNT_VALUE_RST      = 8'h00;
   localparam logic [7:0]  COMPARE_RST          = 8'hFF;
   localparam logic [7:0]  COUNT_MAX            = 8'hFF;

   // flag and enable positions, shared by status, clear and enable registers
   localparam int          BIT_MATCH_B          = 7;
   localparam int          BIT_MATCH_A          = 6;
   localparam int          BIT_OVERFLOW         = 5;
   localparam logic [7:0]  IRQ_BITS_MASK        = 8'hE0;

   // prescale select positions in the serial/timer control register
   localparam int          BIT_PRESCALE_1       = 1;
   localparam int          BIT_PRESCALE_0       = 0;
   localparam logic [7:0]  SERIAL_TIMER_MASK    = 8'h03;

   // prescaler divide ratios
   localparam int          DIV_CODE1_LO         = 8;
   localparam int          DIV_CODE1_HI         = 2;
   localparam int          DIV_CODE2_LO         = 64;
   localparam int          DIV_CODE2_HI         = 32;
   localparam int          DIV_CODE3_LO         = 1024;
   localparam int          DIV_CODE3_HI         = 256;
   localparam int          PRESCALE_WIDTH       = 10;

   typedef enum logic [1:0] {
      TCS_CLR_NEVER,
      TCS_CLR_MATCH_A,
      TCS_CLR_MATCH_B,
      TCS_CLR_EXT_PIN
   } tcs_clear_type;

   typedef enum logic [2:0] {
      TCS_CKS_STOP,
      TCS_CKS_INT1,
      TCS_CKS_INT2,
      TCS_CKS_INT3,
      TCS_CKS_OFF4,
      TCS_CKS_EXT_RISE,
      TCS_CKS_EXT_FALL,
      TCS_CKS_EXT_BOTH
   } tcs_clock_type;

   typedef struct packed {
      logic          match_b_irq_enable;
      logic          match_a_irq_enable;
      logic          overflow_irq_enable;
      tcs_clear_type clear_select;
      tcs_clock_type clock_select;
   } tcs_ctrl_type;

   typedef struct packed {
      logic rise;
      logic fall;
   } tcs_edge_type;

endpackage

//--- core/tcs_pin_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for one pin plus edge detection on the clean copy
module tcs_pin_sync (
   input  wire logic               core_clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               pin_i,
   output tcs_pkg::tcs_edge_type   edge_o
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign edge_o.rise = sync_r & ~prev_r;
   assign edge_o.fall = ~sync_r & prev_r;

endmodule // tcs_pin_sync

//--- core/tcs_timer.sv
// Summary of operation
// - reset or standby loads the timer control register with zero
// - timer control is eight bits, every bit readable and writable
// - bit 7 enable passes compare-B flag to its interrupt request
// - bit 6 enable passes compare-A flag to its interrupt request
// - bit 5 enable passes overflow flag to its interrupt request
// - clear select 00 never, 01 on match A, 10 on match B
// - clear select 11 clears counter on external reset pin rising edge
// - clock source from three clock select bits plus two prescale bits
// - external clock codes pick rising, falling or both edges
// - internal sources count on falling edge of prescaled clock
// - clock select 000 stops the counter
// - code 001 counts clock/8, or clock/2 with prescale bit 0 set
// - code 010 with prescale bit 1 clear counts clock/64
// - wrap from FF to 00 sets the overflow flag
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module tcs_timer #(
   parameter int DIV_CODE2_HI = tcs_pkg::DIV_CODE2_HI,
   parameter int DIV_CODE3_LO = tcs_pkg::DIV_CODE3_LO,
   parameter int DIV_CODE3_HI = tcs_pkg::DIV_CODE3_HI
) (
   input  wire logic                                core_clk_i,
   input  wire logic                                sys_rst_i,
   input  wire logic                                standby_i,
   input  wire logic                                psel_i,
   input  wire logic                                penable_i,
   input  wire logic                                pwrite_i,
   input  wire logic [tcs_pkg::ADDR_WIDTH-1:0]      paddr_i,
   input  wire logic [tcs_pkg::DATA_WIDTH-1:0]      pwdata_i,
   input  wire logic [3:0]                          pstrb_i,
   output logic                                     pready_o,
   output logic [tcs_pkg::DATA_WIDTH-1:0]           prdata_o,
   output logic                                     pslverr_o,
   input  wire logic                                ext_count_clock_in_i,
   input  wire logic                                ext_counter_reset_in_i,
   output logic                                     match_b_irq_o,
   output logic                                     match_a_irq_o,
   output logic                                     overflow_irq_o,
   output logic                                     irq_o
);

   tcs_pkg::tcs_ctrl_type                   timer_control_r;
   logic [7:0]                              serial_timer_control_r;
   logic [7:0]                              count_value_r;
   logic [7:0]                              compare_a_r;
   logic [7:0]                              compare_b_r;
   logic [7:0]                              irq_status_r;
   logic [7:0]                              irq_enable_r;
   logic [tcs_pkg::PRESCALE_WIDTH-1:0]      prescale_r;
   logic                                    pready_r;
   logic [tcs_pkg::DATA_WIDTH-1:0]          prdata_r;
   logic                                    pslverr_r;
   logic                                    match_b_irq_r;
   logic                                    match_a_irq_r;
   logic                                    overflow_irq_r;
   logic                                    irq_r;

   tcs_pkg::tcs_edge_type                   clk_edge;
   tcs_pkg::tcs_edge_type                   rst_edge;

   logic                                    setup_phase;
   logic                                    wr_en;
   logic                                    wr_lane0;
   logic                                    addr_hit;
   logic [7:0]                              wbyte;
   logic                                    count_tick;
   logic                                    match_a;
   logic                                    match_b;
   logic                                    clear_on_tick;
   logic                                    ext_clear;
   logic                                    overflow_evt;
   logic [7:0]                              count_nxt;
   logic [7:0]                              status_set;
   logic [7:0]                              status_clr;
   logic [7:0]                              read_nxt;

   // falling edge of bit log2(div)-1 of a free-running prescaler
   function automatic logic prescale_fall(
      input logic [tcs_pkg::PRESCALE_WIDTH-1:0] cnt,
      input int                                 div
   );
      logic [tcs_pkg::PRESCALE_WIDTH-1:0] low_mask;
      low_mask = tcs_pkg::PRESCALE_WIDTH'(div - 1);
      return (cnt & low_mask) == low_mask;
   endfunction

   function automatic logic addr_is(
      input logic [tcs_pkg::ADDR_WIDTH-1:0] addr,
      input logic [tcs_pkg::ADDR_WIDTH-1:0] target
   );
      return addr == target;
   endfunction

   tcs_pin_sync u_clk_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .pin_i      (ext_count_clock_in_i),
      .edge_o     (clk_edge)
   );

   tcs_pin_sync u_rst_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .pin_i      (ext_counter_reset_in_i),
      .edge_o     (rst_edge)
   );

   // apb decode: setup latches the answer, access phase carries pready
   assign setup_phase = psel_i & ~penable_i & ~pready_r;
   assign wr_en       = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;
   assign wr_lane0    = wr_en & pstrb_i[0];
   assign wbyte       = pwdata_i[7:0];

   always_comb begin
      addr_hit = addr_is(paddr_i, tcs_pkg::ADDR_TIMER_CONTROL)
               | addr_is(paddr_i, tcs_pkg::ADDR_COUNT_VALUE)
               | addr_is(paddr_i, tcs_pkg::ADDR_SERIAL_TIMER)
               | addr_is(paddr_i, tcs_pkg::ADDR_COMPARE_A)
               | addr_is(paddr_i, tcs_pkg::ADDR_COMPARE_B)
               | addr_is(paddr_i, tcs_pkg::ADDR_IRQ_STATUS)
               | addr_is(paddr_i, tcs_pkg::ADDR_IRQ_CLEAR)
               | addr_is(paddr_i, tcs_pkg::ADDR_IRQ_ENABLE);
   end

   always_comb begin
      read_nxt = 8'h00;
      case (paddr_i)
         tcs_pkg::ADDR_TIMER_CONTROL: begin
            read_nxt = timer_control_r;
         end
         tcs_pkg::ADDR_COUNT_VALUE: begin
            read_nxt = count_value_r;
         end
         tcs_pkg::ADDR_SERIAL_TIMER: begin
            read_nxt = serial_timer_control_r;
         end
         tcs_pkg::ADDR_COMPARE_A: begin
            read_nxt = compare_a_r;
         end
         tcs_pkg::ADDR_COMPARE_B: begin
            read_nxt = compare_b_r;
         end
         tcs_pkg::ADDR_IRQ_STATUS: begin
            read_nxt = irq_status_r;
         end
         tcs_pkg::ADDR_IRQ_ENABLE: begin
            read_nxt = irq_enable_r;
         end
         default: begin
            read_nxt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else if (setup_phase) begin
         pready_r  <= 1'b1;
         pslverr_r <= ~addr_hit;
         prdata_r  <= {24'h000000, read_nxt};
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         timer_control_r <= tcs_pkg::TIMER_CONTROL_RST;
      end else if (wr_lane0 && addr_is(paddr_i, tcs_pkg::ADDR_TIMER_CONTROL)) begin
         timer_control_r <= wbyte;
      end
   end

   // only the two prescale bits exist; the rest read as zero
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         serial_timer_control_r <= tcs_pkg::SERIAL_TIMER_RST;
      end else if (wr_lane0 && addr_is(paddr_i, tcs_pkg::ADDR_SERIAL_TIMER)) begin
         serial_timer_control_r <= wbyte & tcs_pkg::SERIAL_TIMER_MASK;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         compare_a_r <= tcs_pkg::COMPARE_RST;
         compare_b_r <= tcs_pkg::COMPARE_RST;
      end else if (wr_lane0) begin
         if (addr_is(paddr_i, tcs_pkg::ADDR_COMPARE_A)) begin
            compare_a_r <= wbyte;
         end
         if (addr_is(paddr_i, tcs_pkg::ADDR_COMPARE_B)) begin
            compare_b_r <= wbyte;
         end
      end
   end

   // prescaler runs free so a source switch does not restart its phase
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         prescale_r <= '0;
      end else begin
         prescale_r <= prescale_r + 1'b1;
      end
   end

   // source from clock select and prescale bits
   always_comb begin
      count_tick = 1'b0;
      case (timer_control_r.clock_select)
         tcs_pkg::TCS_CKS_STOP: begin
            count_tick = 1'b0;
         end
         tcs_pkg::TCS_CKS_INT1: begin
            if (serial_timer_control_r[tcs_pkg::BIT_PRESCALE_0]) begin
               count_tick = prescale_fall(prescale_r, tcs_pkg::DIV_CODE1_HI);
            end else begin
               count_tick = prescale_fall(prescale_r, tcs_pkg::DIV_CODE1_LO);
            end
         end
         tcs_pkg::TCS_CKS_INT2: begin
            if (serial_timer_control_r[tcs_pkg::BIT_PRESCALE_1]) begin
               count_tick = prescale_fall(prescale_r, DIV_CODE2_HI);
            end else begin
               count_tick = prescale_fall(prescale_r, tcs_pkg::DIV_CODE2_LO);
            end
         end
         tcs_pkg::TCS_CKS_INT3: begin
            if (serial_timer_control_r[tcs_pkg::BIT_PRESCALE_1]) begin
               count_tick = prescale_fall(prescale_r, DIV_CODE3_HI);
            end else begin
               count_tick = prescale_fall(prescale_r, DIV_CODE3_LO);
            end
         end
         tcs_pkg::TCS_CKS_EXT_RISE: begin
            count_tick = clk_edge.rise;
         end
         tcs_pkg::TCS_CKS_EXT_FALL: begin
            count_tick = clk_edge.fall;
         end
         tcs_pkg::TCS_CKS_EXT_BOTH: begin
            count_tick = clk_edge.rise | clk_edge.fall;
         end
         default: begin
            count_tick = 1'b0;
         end
      endcase
   end

   assign match_a = count_value_r == compare_a_r;
   assign match_b = count_value_r == compare_b_r;

   // clear on external reset rising edge
   always_comb begin
      clear_on_tick = 1'b0;
      ext_clear     = 1'b0;
      case (timer_control_r.clear_select)
         tcs_pkg::TCS_CLR_NEVER: begin
            clear_on_tick = 1'b0;
         end
         tcs_pkg::TCS_CLR_MATCH_A: begin
            clear_on_tick = match_a;
         end
         tcs_pkg::TCS_CLR_MATCH_B: begin
            clear_on_tick = match_b;
         end
         tcs_pkg::TCS_CLR_EXT_PIN: begin
            ext_clear = rst_edge.rise;
         end
         default: begin
            clear_on_tick = 1'b0;
         end
      endcase
   end

   assign overflow_evt = count_tick & ~clear_on_tick & ~ext_clear
                       & (count_value_r == tcs_pkg::COUNT_MAX);

   always_comb begin
      count_nxt = count_value_r;
      if (ext_clear) begin
         count_nxt = tcs_pkg::COUNT_VALUE_RST;
      end else if (count_tick) begin
         if (clear_on_tick) begin
            count_nxt = tcs_pkg::COUNT_VALUE_RST;
         end else begin
            count_nxt = count_value_r + 8'h01;
         end
      end
   end

   // a software write to the count beats any tick in that cycle
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         count_value_r <= tcs_pkg::COUNT_VALUE_RST;
      end else if (wr_lane0 && addr_is(paddr_i, tcs_pkg::ADDR_COUNT_VALUE)) begin
         count_value_r <= wbyte;
      end else begin
         count_value_r <= count_nxt;
      end
   end

   // matches are flagged only while the counter is running
   always_comb begin
      status_set = 8'h00;
      status_set[tcs_pkg::BIT_MATCH_B]  = match_b & count_tick;
      status_set[tcs_pkg::BIT_MATCH_A]  = match_a & count_tick;
      status_set[tcs_pkg::BIT_OVERFLOW] = overflow_evt;
   end

   assign status_clr = (wr_lane0 && addr_is(paddr_i, tcs_pkg::ADDR_IRQ_CLEAR)) ?
                       (wbyte & tcs_pkg::IRQ_BITS_MASK) : 8'h00;

   // sticky flags: a set in the clearing cycle survives
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         irq_status_r <= 8'h00;
      end else begin
         irq_status_r <= (irq_status_r & ~status_clr) | status_set;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         irq_enable_r <= 8'h00;
      end else if (wr_lane0 && addr_is(paddr_i, tcs_pkg::ADDR_IRQ_ENABLE)) begin
         irq_enable_r <= wbyte & tcs_pkg::IRQ_BITS_MASK;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         match_b_irq_r  <= 1'b0;
         match_a_irq_r  <= 1'b0;
         overflow_irq_r <= 1'b0;
         irq_r          <= 1'b0;
      end else begin
         match_b_irq_r  <= irq_status_r[tcs_pkg::BIT_MATCH_B]
                         & timer_control_r.match_b_irq_enable;
         match_a_irq_r  <= irq_status_r[tcs_pkg::BIT_MATCH_A]
                         & timer_control_r.match_a_irq_enable;
         overflow_irq_r <= irq_status_r[tcs_pkg::BIT_OVERFLOW]
                         & timer_control_r.overflow_irq_enable;
         irq_r          <= |(irq_status_r & irq_enable_r);
      end
   end

   assign pready_o       = pready_r;
   assign prdata_o       = prdata_r;
   assign pslverr_o      = pslverr_r;
   assign match_b_irq_o  = match_b_irq_r;
   assign match_a_irq_o  = match_a_irq_r;
   assign overflow_irq_o = overflow_irq_r;
   assign irq_o          = irq_r;

endmodule // tcs_timer

//--- tb/tcs_pin_model.sv
`timescale 1ns/1ps

module tcs_pin_model (
   input  wire logic core_clk_i,
   output logic      count_clock_o,
   output logic      counter_reset_o
);
   // both pins rest low between bursts, as an idle board line would
   initial begin
      count_clock_o   = 1'b0;
      counter_reset_o = 1'b0;
   end

   // half is the level time in clocks: 2 is prompt, larger is slow
   task automatic pulses(input int n, input int half);
      repeat (n) begin
         @(posedge core_clk_i);
         count_clock_o <= 1'b1;
         repeat (half) @(posedge core_clk_i);
         count_clock_o <= 1'b0;
         repeat (half - 1) @(posedge core_clk_i);
      end
   endtask

   task automatic reset_pulse(input int half);
      @(posedge core_clk_i);
      counter_reset_o <= 1'b1;
      repeat (half) @(posedge core_clk_i);
      counter_reset_o <= 1'b0;
   endtask
endmodule // tcs_pin_model

//--- tb/tcs_timer_monitor.sv
`timescale 1ns/1ps

module tcs_timer_monitor #(
   parameter int DIV_CODE2_HI = tcs_pkg::DIV_CODE2_HI,
   parameter int DIV_CODE3_LO = tcs_pkg::DIV_CODE3_LO,
   parameter int DIV_CODE3_HI = tcs_pkg::DIV_CODE3_HI
) (
   input wire logic        core_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        standby_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        ext_count_clock_in_i,
   input wire logic        ext_counter_reset_in_i,
   input wire logic        match_b_irq_o,
   input wire logic        match_a_irq_o,
   input wire logic        overflow_irq_o,
   input wire logic        irq_o
);
   logic [7:0] ctl_r;
   logic [2:0] en_r;
   logic       wr_ok;

   assign wr_ok = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];

   // shadows let the irq gates be judged from the pins alone
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || standby_i) begin
         ctl_r <= 8'h00;
         en_r  <= 3'h0;
      end else if (wr_ok) begin
         if (paddr_i == tcs_pkg::ADDR_TIMER_CONTROL) ctl_r <= pwdata_i[7:0];
         if (paddr_i == tcs_pkg::ADDR_IRQ_ENABLE) en_r <= pwdata_i[7:5];
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_ready_next;
      psel_i && !penable_i |=> pready_o;
   endproperty
   a_ready_next: assert property (p_ready_next) else $error("no ready after setup");

   property p_ready_cause;
      pready_o |-> $past(psel_i && !penable_i) && psel_i && penable_i;
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without request");

   property p_ready_single;
      pready_o |=> !pready_o;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready held too long");

   property p_err_ready;
      pslverr_o |-> pready_o && (paddr_i < tcs_pkg::ADDR_TIMER_CONTROL ||
                                 paddr_i > tcs_pkg::ADDR_IRQ_ENABLE);
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error on mapped address");

   property p_ctl_read;
      psel_i && penable_i && !pwrite_i && paddr_i == tcs_pkg::ADDR_TIMER_CONTROL
         |-> prdata_o == {24'h000000, ctl_r};
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");

   property p_mb_gate;
      match_b_irq_o |-> $past(ctl_r[7]);
   endproperty
   a_mb_gate: assert property (p_mb_gate) else $error("match b request ungated");

   property p_ma_gate;
      match_a_irq_o |-> $past(ctl_r[6]);
   endproperty
   a_ma_gate: assert property (p_ma_gate) else $error("match a request ungated");

   property p_ov_gate;
      $fell(ctl_r[5]) |=> !overflow_irq_o [*3];
   endproperty
   a_ov_gate: assert property (p_ov_gate) else $error("overflow request ungated");

   property p_irq_gate;
      irq_o |-> $past(en_r != 3'h0);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
endmodule // tcs_timer_monitor

bind tcs_timer tcs_timer_monitor #(
   .DIV_CODE2_HI(DIV_CODE2_HI), .DIV_CODE3_LO(DIV_CODE3_LO), .DIV_CODE3_HI(DIV_CODE3_HI)
) u_tcs_timer_monitor (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .standby_i(standby_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
   .pslverr_o(pslverr_o), .ext_count_clock_in_i(ext_count_clock_in_i),
   .ext_counter_reset_in_i(ext_counter_reset_in_i), .match_b_irq_o(match_b_irq_o),
   .match_a_irq_o(match_a_irq_o), .overflow_irq_o(overflow_irq_o), .irq_o(irq_o)
);

//--- tb/tcs_timer_tb.sv
`timescale 1ns/1ps

module tcs_timer_tb;
   typedef struct {
      logic        rd;
      logic [31:0] lo;
      logic [31:0] hi;
      logic        err;
   } tcs_note_type;
   localparam logic [15:0] A_TC = tcs_pkg::ADDR_TIMER_CONTROL;
   localparam logic [15:0] A_CNT = tcs_pkg::ADDR_COUNT_VALUE;
   localparam logic [15:0] A_ST = tcs_pkg::ADDR_SERIAL_TIMER;
   localparam logic [15:0] A_IS = tcs_pkg::ADDR_IRQ_STATUS;
   logic        clk, rst, stby, psel, pen, pwr, prdy, perr, mb, ma, ov, irq, ok;
   logic        pin_clk, pin_rst;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, d;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          n, e, lo, hi;
   int          ck[9] = '{0, 1, 1, 1, 2, 2, 3, 3, 4};
   int          ps[9] = '{0, 0, 1, 2, 0, 2, 0, 3, 0};
   int          dv[9] = '{0, 8, 2, 8, 64, 4, 16, 8, 0};
   tcs_note_type notes[$];
   tcs_note_type cur;

   tcs_timer #(.DIV_CODE2_HI(4), .DIV_CODE3_LO(16), .DIV_CODE3_HI(8)) u_tcs_timer (
      .core_clk_i(clk), .sys_rst_i(rst), .standby_i(stby), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(4'hF), .pready_o(prdy), .prdata_o(prdata), .pslverr_o(perr),
      .ext_count_clock_in_i(pin_clk), .ext_counter_reset_in_i(pin_rst),
      .match_b_irq_o(mb), .match_a_irq_o(ma), .overflow_irq_o(ov), .irq_o(irq));
   tcs_pin_model u_tcs_pin_model (
      .core_clk_i(clk), .count_clock_o(pin_clk), .counter_reset_o(pin_rst));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic close_out();
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // the note goes in before the request so the watcher never runs ahead
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dat,
                      input logic [31:0] l, input logic [31:0] h);
      notes.push_back(tcs_note_type'{!w, l, h, a < A_TC || a > tcs_pkg::ADDR_IRQ_ENABLE});
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= dat;
      @(posedge clk);
      pen    <= 1'b1;
      // no local limit: a hung slave is caught by the bench timeout
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      psel   <= 1'b0;
      pen    <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      apb(1'b1, a, {24'h000000, v}, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] l, input logic [31:0] h);
      apb(1'b0, a, 32'h0, l, h);
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask

   // answer taken at the same edge that ends the access phase
   always @(posedge clk) begin
      if (prdy === 1'b1) begin
         cur = notes.size() ? notes.pop_front() : tcs_note_type'{1'b1, 32'h1, 32'h0, 1'b0};
         ok = (perr === cur.err) && (!cur.rd || (prdata >= cur.lo && prdata <= cur.hi));
         n_checks++;
         if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, prdata, cur.lo);
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      rst = 1'b1;
      stby = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      void'($urandom(38));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(A_TC, 32'h0, 32'h0);
      rd(16'h0000, 32'h0, 32'h0);
      repeat (6) begin
         d = $urandom;
         apb(1'b1, A_TC, d, 32'h0, 32'h0);
         rd(A_TC, {24'h0, d[7:0]}, {24'h0, d[7:0]});
      end
      @(posedge clk);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      rd(A_TC, 32'h0, 32'h0);
      for (int i = 0; i < 9; i++) begin
         wr(A_ST, ps[i][7:0]);
         wr(A_TC, ck[i][7:0]);
         wr(A_CNT, 8'h00);
         settle(200);
         lo = dv[i] ? 200 / dv[i] - 1 : 0;
         hi = dv[i] ? 204 / dv[i] + 1 : 0;
         rd(A_CNT, lo, hi);
      end
      for (int i = 0; i < 3; i++) begin
         n = $urandom_range(9, 1);
         e = (i == 2) ? 2 * n : n;
         wr(A_TC, 8'h05 + i[7:0]);
         wr(A_CNT, 8'h00);
         u_tcs_pin_model.pulses(n, 2 + 3 * i);
         settle(6);
         rd(A_CNT, e, e);
      end
      wr(tcs_pkg::ADDR_COMPARE_A, 8'h10);
      wr(tcs_pkg::ADDR_COMPARE_B, 8'h20);
      wr(A_ST, 8'h01);
      for (int s = 0; s < 3; s++) begin
         wr(A_TC, {3'h0, s[1:0], 3'h1});
         wr(A_CNT, 8'h00);
         settle(100);
         rd(A_CNT, s ? 0 : 47, s ? 16 * s : 54);
      end
      for (int s = 0; s < 4; s += 3) begin
         wr(A_TC, {3'h0, s[1:0], 3'h0});
         wr(A_CNT, 8'h77);
         u_tcs_pin_model.reset_pulse(3);
         settle(6);
         rd(A_CNT, s ? 0 : 32'h77, s ? 0 : 32'h77);
      end
      wr(tcs_pkg::ADDR_IRQ_CLEAR, 8'hE0);
      wr(tcs_pkg::ADDR_IRQ_ENABLE, 8'hE0);
      wr(A_CNT, 8'hF0);
      wr(A_TC, 8'hE1);
      settle(40);
      wr(A_TC, 8'hE0);
      settle(2);
      chk({ov, ma, mb, irq}, 4'h9);
      rd(A_IS, 32'h20, 32'h20);
      wr(A_TC, 8'hC0);
      settle(2);
      chk({ov, irq}, 2'h1);
      wr(tcs_pkg::ADDR_IRQ_ENABLE, 8'h00);
      settle(2);
      chk(irq, 1'h0);
      wr(tcs_pkg::ADDR_IRQ_ENABLE, 8'hE0);
      wr(tcs_pkg::ADDR_IRQ_CLEAR, 8'h20);
      settle(2);
      chk(irq, 1'h0);
      rd(A_IS, 32'h0, 32'h0);
      wr(tcs_pkg::ADDR_COMPARE_A, 8'h05);
      wr(tcs_pkg::ADDR_COMPARE_B, 8'h05);
      wr(A_CNT, 8'h00);
      wr(A_TC, 8'hC1);
      settle(20);
      wr(A_TC, 8'hC0);
      settle(2);
      chk({mb, ma}, 2'h3);
      wr(A_TC, 8'h00);
      settle(2);
      chk({mb, ma, irq}, 3'h1);
      chk(notes.size(), 32'h0);
      close_out();
   end
endmodule // tcs_timer_tb
